// [rtl/scc_pkg.sv]
// Purpose: shared constants for the sensor cpu instruction core
// Assumes: byte-wide program memory, sixteen 16-bit core registers
// Notes: op codes 8..f are not executed here, they go to a side unit
package scc_pkg;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int SEL_W = 4;
  localparam int NUM_REGS = 16;
  // program partition and information partition sizes in bytes
  localparam int PROG_BYTES = 4096;
  localparam int INFO_BYTES = 128;
  localparam int PAGE_BYTES = 64;
  localparam int PROG_AW = 12;
  localparam int ADDR_W = 16;
  localparam logic [BYTE_W-1:0] ERASED_BYTE = 8'hff;
  localparam logic [ADDR_W-1:0] PC_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] PC_STEP = 16'h0001;
  // instruction byte layout
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 4;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 0;
  // op codes handled by this core
  localparam logic [SEL_W-1:0] OP_LOAD_IMM = 4'h0;
  localparam logic [SEL_W-1:0] OP_CLEAR = 4'h1;
  localparam logic [SEL_W-1:0] OP_AND_ACC = 4'h2;
  localparam logic [SEL_W-1:0] OP_OR_ACC = 4'h3;
  localparam logic [SEL_W-1:0] OP_ADD_ACC = 4'h4;
  localparam logic [SEL_W-1:0] OP_STORE_ACC = 4'h5;
  localparam logic [SEL_W-1:0] OP_SHIFT_LEFT = 4'h6;
  localparam logic [SEL_W-1:0] OP_SHIFT_RIGHT = 4'h7;
  // left shift chaining: register six takes the msb of register four
  localparam logic [SEL_W-1:0] CHAINED_SHIFT_IDX = 4'h6;
  localparam logic [SEL_W-1:0] SHIFT_CARRY_SRC_IDX = 4'h4;
  localparam logic [SEL_W-1:0] ACC_IDX_DEFAULT = 4'h0;
  // sequencer states, gray along fetch -> high byte -> low byte
  typedef enum logic [1:0] {
    ST_FETCH = 2'h0,
    ST_IMM_HI = 2'h1,
    ST_IMM_LO = 2'h3
  } scc_state_t;
endpackage

// [rtl/scc_alu.sv]
// Purpose: single-cycle execution of the one-byte instructions
// Assumes: load-immediate is sequenced by the core, never fired here
// Notes: purely combinational; one destination per instruction
`timescale 1ns/1ps
module scc_alu (
  input wire logic [scc_pkg::SEL_W-1:0] op_code,
  input wire logic [scc_pkg::SEL_W-1:0] sel,
  input wire logic [scc_pkg::DATA_W-1:0] x_val,
  input wire logic [scc_pkg::DATA_W-1:0] acc_val,
  input wire logic carry_msb,
  output logic wr_en,
  output logic wr_acc,
  output logic [scc_pkg::DATA_W-1:0] wr_data,
  output logic ext_op
);
  wire chained_shift = (sel == scc_pkg::CHAINED_SHIFT_IDX);
  wire shl_fill = chained_shift ? carry_msb : 1'b0;

  // decode op code to one write of either x or the accumulator
  always_comb begin
    wr_en = 1'b1;
    wr_acc = 1'b0;
    wr_data = x_val;
    ext_op = 1'b0;
    unique case (op_code)
      scc_pkg::OP_CLEAR: wr_data = '0;
      scc_pkg::OP_AND_ACC: begin
        wr_acc = 1'b1;
        wr_data = acc_val & x_val;
      end
      scc_pkg::OP_OR_ACC: begin
        wr_acc = 1'b1;
        wr_data = acc_val | x_val;
      end
      scc_pkg::OP_ADD_ACC: begin
        wr_acc = 1'b1;
        wr_data = acc_val + x_val;
      end
      scc_pkg::OP_STORE_ACC: wr_data = acc_val;
      scc_pkg::OP_SHIFT_LEFT: wr_data = {x_val[scc_pkg::DATA_W-2:0], shl_fill};
      scc_pkg::OP_SHIFT_RIGHT: begin
        wr_data = {x_val[scc_pkg::DATA_W-1], x_val[scc_pkg::DATA_W-1:1]};
      end
      default: begin
        // unknown here: no write, flagged for the side unit
        wr_en = 1'b0;
        ext_op = 1'b1;
      end
    endcase
  end
endmodule

// [rtl/scc_flash.sv]
// Purpose: program and information flash partitions
// Assumes: maintenance port is driven by the serial interface logic
// Notes: erase and write complete in one cycle; no wear or timing model
`timescale 1ns/1ps
module scc_flash #(
  parameter int PROG_DEPTH = scc_pkg::PROG_BYTES,
  parameter int INFO_DEPTH = scc_pkg::INFO_BYTES,
  parameter int PAGE_DEPTH = scc_pkg::PAGE_BYTES
) (
  input wire logic clk,
  input wire logic [$clog2(PROG_DEPTH)-1:0] core_addr,
  output logic [scc_pkg::BYTE_W-1:0] core_data,
  input wire logic mnt_part,
  input wire logic [scc_pkg::ADDR_W-1:0] mnt_addr,
  input wire logic [scc_pkg::BYTE_W-1:0] mnt_wdata,
  input wire logic mnt_write,
  input wire logic mnt_page_erase,
  input wire logic mnt_all_erase,
  output logic [scc_pkg::BYTE_W-1:0] mnt_rdata
);
  localparam int PA_W = $clog2(PROG_DEPTH);
  localparam int IA_W = $clog2(INFO_DEPTH);
  localparam int PG_W = $clog2(PAGE_DEPTH);

  logic [scc_pkg::BYTE_W-1:0] prog_mem [PROG_DEPTH];
  logic [scc_pkg::BYTE_W-1:0] info_mem [INFO_DEPTH];

  // upper address bits never reach the decode
  wire [PA_W-1:0] prog_addr = mnt_addr[PA_W-1:0];
  wire [IA_W-1:0] info_addr = mnt_addr[IA_W-1:0];
  wire prog_sel = !mnt_part;

  // the core sees only partition 0, read only
  assign core_data = prog_mem[core_addr];
  assign mnt_rdata = mnt_part ? info_mem[info_addr] : prog_mem[prog_addr];

  // partition 0: bulk or 64-byte page erase, bit-clearing byte write
  always_ff @(posedge clk) begin
    if (prog_sel && mnt_all_erase) begin
      for (int i = 0; i < PROG_DEPTH; i++) prog_mem[i] <= scc_pkg::ERASED_BYTE;
    end else if (prog_sel && mnt_page_erase) begin
      for (int i = 0; i < PAGE_DEPTH; i++) begin
        prog_mem[{prog_addr[PA_W-1:PG_W], PG_W'(i)}] <= scc_pkg::ERASED_BYTE;
      end
    end else if (prog_sel && mnt_write) begin
      // flash programming can only clear bits
      prog_mem[prog_addr] <= prog_mem[prog_addr] & mnt_wdata;
    end
  end

  // partition 1: two pages, never touched by partition 0 actions
  always_ff @(posedge clk) begin
    if (mnt_part && mnt_all_erase) begin
      for (int i = 0; i < INFO_DEPTH; i++) info_mem[i] <= scc_pkg::ERASED_BYTE;
    end else if (mnt_part && mnt_page_erase) begin
      for (int i = 0; i < PAGE_DEPTH; i++) begin
        info_mem[{info_addr[IA_W-1:PG_W], PG_W'(i)}] <= scc_pkg::ERASED_BYTE;
      end
    end else if (mnt_part && mnt_write) begin
      info_mem[info_addr] <= info_mem[info_addr] & mnt_wdata;
    end
  end
endmodule

// [rtl/scc_core.sv]
// Purpose: sixteen-bit sensor cpu core, fetch, decode and execute
// Assumes: flash maintenance signals come from logic on clk
// Notes: run only gates the start of an instruction
`timescale 1ns/1ps
module scc_core #(
  parameter logic [scc_pkg::SEL_W-1:0] ACC_IDX = scc_pkg::ACC_IDX_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic mnt_part,
  input wire logic [scc_pkg::ADDR_W-1:0] mnt_addr,
  input wire logic [scc_pkg::BYTE_W-1:0] mnt_wdata,
  input wire logic mnt_write,
  input wire logic mnt_page_erase,
  input wire logic mnt_all_erase,
  output logic [scc_pkg::ADDR_W-1:0] pc_reg,
  output logic [scc_pkg::DATA_W-1:0] acc_reg,
  output logic retire_reg,
  output logic ext_valid_reg,
  output logic [scc_pkg::BYTE_W-1:0] ext_instr_reg,
  output logic [scc_pkg::BYTE_W-1:0] mnt_rdata_reg
);
  logic rstn_meta_reg;
  logic rst_n;
  scc_pkg::scc_state_t state_reg;
  scc_pkg::scc_state_t state_next;
  logic [scc_pkg::SEL_W-1:0] load_dest_reg;
  logic [scc_pkg::BYTE_W-1:0] imm_hi_reg;
  logic [scc_pkg::DATA_W-1:0] regs [scc_pkg::NUM_REGS];
  logic [scc_pkg::BYTE_W-1:0] fetch_byte;
  logic [scc_pkg::BYTE_W-1:0] mnt_rdata;
  logic alu_wr_en;
  logic alu_wr_acc;
  logic [scc_pkg::DATA_W-1:0] alu_data;
  logic alu_ext;

  // reset asserts at once and releases through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstn_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rstn_meta_reg <= 1'b1;
      rst_n <= rstn_meta_reg;
    end
  end

  // flash: the core reads partition 0 through the low pc bits only
  scc_flash u_flash (
    .clk(clk),
    .core_addr(pc_reg[scc_pkg::PROG_AW-1:0]),
    .core_data(fetch_byte),
    .mnt_part(mnt_part),
    .mnt_addr(mnt_addr),
    .mnt_wdata(mnt_wdata),
    .mnt_write(mnt_write),
    .mnt_page_erase(mnt_page_erase),
    .mnt_all_erase(mnt_all_erase),
    .mnt_rdata(mnt_rdata)
  );

  // instruction byte split and operand selection
  wire [scc_pkg::SEL_W-1:0] op_code = fetch_byte[scc_pkg::OP_MSB:scc_pkg::OP_LSB];
  wire [scc_pkg::SEL_W-1:0] sel = fetch_byte[scc_pkg::SEL_MSB:scc_pkg::SEL_LSB];
  wire [scc_pkg::DATA_W-1:0] x_val = regs[sel];
  wire [scc_pkg::DATA_W-1:0] acc_val = regs[ACC_IDX];
  wire carry_msb = regs[scc_pkg::SHIFT_CARRY_SRC_IDX][scc_pkg::DATA_W-1];

  scc_alu u_alu (
    .op_code(op_code),
    .sel(sel),
    .x_val(x_val),
    .acc_val(acc_val),
    .carry_msb(carry_msb),
    .wr_en(alu_wr_en),
    .wr_acc(alu_wr_acc),
    .wr_data(alu_data),
    .ext_op(alu_ext)
  );

  // an instruction starts only at a fetch with run high
  wire fetch_go = run && (state_reg == scc_pkg::ST_FETCH);
  wire is_load = (op_code == scc_pkg::OP_LOAD_IMM);
  wire single_go = fetch_go && !is_load;
  wire load_go = fetch_go && is_load;
  wire load_fire = (state_reg == scc_pkg::ST_IMM_LO);
  wire alu_fire = single_go && alu_wr_en;
  // pc moves on every cycle that consumes a program byte
  wire pc_adv = fetch_go || (state_reg != scc_pkg::ST_FETCH);

  // single write port: load result, or the alu's one destination
  wire wr_en = load_fire || alu_fire;
  wire [scc_pkg::SEL_W-1:0] alu_idx = alu_wr_acc ? ACC_IDX : sel;
  wire [scc_pkg::SEL_W-1:0] wr_idx = load_fire ? load_dest_reg : alu_idx;
  wire [scc_pkg::DATA_W-1:0] load_word = {imm_hi_reg, fetch_byte};
  wire [scc_pkg::DATA_W-1:0] wr_data = load_fire ? load_word : alu_data;
  wire acc_hit = wr_en && (wr_idx == ACC_IDX);
  wire retire_next = single_go || load_fire;
  wire ext_next = single_go && alu_ext;

  // load sequencer: opcode byte, high byte, low byte
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      scc_pkg::ST_FETCH: if (load_go) state_next = scc_pkg::ST_IMM_HI;
      scc_pkg::ST_IMM_HI: state_next = scc_pkg::ST_IMM_LO;
      scc_pkg::ST_IMM_LO: state_next = scc_pkg::ST_FETCH;
      default: state_next = scc_pkg::ST_FETCH;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state_reg <= scc_pkg::ST_FETCH;
    else state_reg <= state_next;
  end

  // program counter wraps in 16 bits; the decode drops the top nibble
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pc_reg <= scc_pkg::PC_RESET;
    else if (pc_adv) pc_reg <= pc_reg + scc_pkg::PC_STEP;
  end

  // load destination and high byte are held across the sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_dest_reg <= '0;
      imm_hi_reg <= '0;
    end else begin
      if (load_go) load_dest_reg <= sel;
      if (state_reg == scc_pkg::ST_IMM_HI) imm_hi_reg <= fetch_byte;
    end
  end

  // register file: only the selected entry is written
  for (genvar i = 0; i < scc_pkg::NUM_REGS; i++) begin : g_reg
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) regs[i] <= '0;
      else if (wr_en && (wr_idx == scc_pkg::SEL_W'(i))) regs[i] <= wr_data;
    end
  end

  // observation outputs, all registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= '0;
      retire_reg <= 1'b0;
      ext_valid_reg <= 1'b0;
      ext_instr_reg <= '0;
      mnt_rdata_reg <= '0;
    end else begin
      if (acc_hit) acc_reg <= wr_data;
      retire_reg <= retire_next;
      ext_valid_reg <= ext_next;
      if (ext_next) ext_instr_reg <= fetch_byte;
      mnt_rdata_reg <= mnt_rdata;
    end
  end

  // checks on the sequencing and the datapath
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_reset_pc;
    $rose(rst_n) |-> (pc_reg == scc_pkg::PC_RESET) && (state_reg == scc_pkg::ST_FETCH);
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("pc not zero after reset");

  property p_single_step;
    single_go |=> (pc_reg == $past(pc_reg) + scc_pkg::PC_STEP) && retire_reg
      && (state_reg == scc_pkg::ST_FETCH);
  endproperty
  a_single_step: assert property (p_single_step) else $error("single byte op misstep");

  sequence s_load_start;
    load_go;
  endsequence
  sequence s_load_body;
    (state_reg == scc_pkg::ST_IMM_HI) ##1 (state_reg == scc_pkg::ST_IMM_LO);
  endsequence
  property p_load_seq;
    s_load_start |=> s_load_body ##1
      ((state_reg == scc_pkg::ST_FETCH) && retire_reg
      && (pc_reg == $past(pc_reg, 3) + 16'h0003));
  endproperty
  a_load_seq: assert property (p_load_seq) else $error("load sequence wrong");

  property p_load_data;
    load_fire |=> regs[$past(load_dest_reg)] == $past(load_word);
  endproperty
  a_load_data: assert property (p_load_data) else $error("load value wrong");

  property p_clear;
    single_go && (op_code == scc_pkg::OP_CLEAR) |=> regs[$past(sel)] == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_and;
    single_go && (op_code == scc_pkg::OP_AND_ACC)
      |=> acc_reg == ($past(acc_val) & $past(x_val));
  endproperty
  a_and: assert property (p_and) else $error("and result wrong");

  property p_or;
    single_go && (op_code == scc_pkg::OP_OR_ACC)
      |=> acc_reg == ($past(acc_val) | $past(x_val));
  endproperty
  a_or: assert property (p_or) else $error("or result wrong");

  property p_add;
    single_go && (op_code == scc_pkg::OP_ADD_ACC)
      |=> regs[ACC_IDX] == scc_pkg::DATA_W'($past(acc_val) + $past(x_val));
  endproperty
  a_add: assert property (p_add) else $error("add result wrong");

  property p_store;
    single_go && (op_code == scc_pkg::OP_STORE_ACC)
      |=> (regs[$past(sel)] == $past(acc_val)) && (acc_reg == $past(acc_reg));
  endproperty
  a_store: assert property (p_store) else $error("store wrong");

  property p_shift_chain;
    single_go && (op_code == scc_pkg::OP_SHIFT_LEFT) && (sel == scc_pkg::CHAINED_SHIFT_IDX)
      |=> (regs[scc_pkg::CHAINED_SHIFT_IDX][0] == $past(carry_msb))
      && (regs[scc_pkg::SHIFT_CARRY_SRC_IDX] == $past(regs[scc_pkg::SHIFT_CARRY_SRC_IDX]));
  endproperty
  a_shift_chain: assert property (p_shift_chain) else $error("chained shift wrong");

  property p_shift_right;
    single_go && (op_code == scc_pkg::OP_SHIFT_RIGHT)
      |=> regs[$past(sel)] == {$past(x_val[scc_pkg::DATA_W-1]), $past(x_val[scc_pkg::DATA_W-1:1])};
  endproperty
  a_shift_right: assert property (p_shift_right) else $error("right shift wrong");

  property p_ext_nop;
    single_go && alu_ext |=> ext_valid_reg && (ext_instr_reg == $past(fetch_byte))
      && (acc_reg == $past(acc_reg));
  endproperty
  a_ext_nop: assert property (p_ext_nop) else $error("external op mishandled");

  // further checks: idle hold, single destination, load operands
  // a plain left shift feeds zero, only the chained register borrows a bit
  property p_shift_left;
    single_go && (op_code == scc_pkg::OP_SHIFT_LEFT) && (sel != scc_pkg::CHAINED_SHIFT_IDX)
      |=> regs[$past(sel)] == {$past(x_val[scc_pkg::DATA_W-2:0]), 1'b0};
  endproperty
  a_shift_left: assert property (p_shift_left) else $error("left shift wrong");

  // with run low the core must not creep forward on its own
  property p_idle_hold;
    (state_reg == scc_pkg::ST_FETCH) && !run |=> $stable(pc_reg) && !retire_reg;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("pc moved while idle");

  // the carry source register is a likely victim of a stray write
  property p_carry_src_kept;
    single_go && (alu_idx != scc_pkg::SHIFT_CARRY_SRC_IDX)
      |=> $stable(regs[scc_pkg::SHIFT_CARRY_SRC_IDX]);
  endproperty
  a_carry_src_kept: assert property (p_carry_src_kept) else $error("extra register written");

  // the destination is latched at the op code byte, before operand bytes arrive
  property p_load_dest;
    load_go |=> load_dest_reg == $past(sel);
  endproperty
  a_load_dest: assert property (p_load_dest) else $error("load destination lost");

  // the two operand bytes are consumed without a retire in between
  property p_load_step;
    s_load_start |=> !retire_reg ##1
      (!retire_reg && (pc_reg == $past(pc_reg, 2) + scc_pkg::PC_STEP + scc_pkg::PC_STEP));
  endproperty
  a_load_step: assert property (p_load_step) else $error("load operand fetch wrong");

  // acc_reg is a shadow, so it must always match the parameterised entry
  property p_acc_copy;
    acc_reg == regs[ACC_IDX];
  endproperty
  a_acc_copy: assert property (p_acc_copy) else $error("accumulator copy stale");
endmodule

// [sim/scc_host_model.sv]
// Purpose: host side of the flash maintenance port, used to load programs
// Assumes: one request per call, strobes stand for exactly one edge
// Notes: kind 0 write, 1 page erase, 2 all erase, 3 address only (read)
`timescale 1ns/1ps
module scc_host_model (
  input wire logic clk,
  output logic mnt_part,
  output logic [scc_pkg::ADDR_W-1:0] mnt_addr,
  output logic [scc_pkg::BYTE_W-1:0] mnt_wdata,
  output logic mnt_write,
  output logic mnt_page_erase,
  output logic mnt_all_erase
);
  // idle levels at time zero so the core never sees an unknown strobe
  initial begin
    mnt_part = 1'b0;
    mnt_addr = 16'h0000;
    mnt_wdata = 8'h00;
    mnt_write = 1'b0;
    mnt_page_erase = 1'b0;
    mnt_all_erase = 1'b0;
  end

  // kind 3 passes the raw address so a read can probe the upper bits
  task automatic mop(input logic [1:0] kind, input logic part, input logic [15:0] addr,
                     input logic [7:0] data);
    @(posedge clk);
    mnt_part <= part;
    mnt_addr <= (kind == 2'd3) ? addr : {4'h0, addr[11:0]};
    mnt_wdata <= data;
    mnt_write <= (kind == 2'd0);
    mnt_page_erase <= (kind == 2'd1);
    mnt_all_erase <= (kind == 2'd2);
    @(posedge clk);
    // released write data is inverted so a stale byte is never mistaken for live data
    mnt_wdata <= ~data;
    mnt_write <= 1'b0;
    mnt_page_erase <= 1'b0;
    mnt_all_erase <= 1'b0;
  endtask
endmodule

// [sim/testbench.sv]
// Purpose: self-checking bench for the sensor cpu instruction core
// Assumes: accumulator placed at register three to exercise the parameter
// Notes: a reference model predicts acc and pc for every retired instruction
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [15:0] acc;
    logic [15:0] pc;
    logic ext;
    logic [7:0] eb;
  } scc_note_t;
  localparam logic [3:0] ACC = 4'h3;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic run = 1'b0;
  logic mnt_part, mnt_write, mnt_page_erase, mnt_all_erase;
  logic [scc_pkg::ADDR_W-1:0] mnt_addr, pc_reg;
  logic [scc_pkg::BYTE_W-1:0] mnt_wdata, ext_instr_reg, mnt_rdata_reg;
  logic [scc_pkg::DATA_W-1:0] acc_reg;
  logic retire_reg, ext_valid_reg;
  int num_errors = 0;
  int check_count = 0;
  integer seed = 32'hbcf83c55;
  logic [31:0] rnd;
  scc_note_t notes[$];
  scc_note_t mon_n;
  logic [7:0] prog[$];
  logic [15:0] xr[16];
  logic [15:0] pc_m;
  int cyc;

  always #2.5 clk = ~clk;

  scc_core #(.ACC_IDX(ACC)) scc_core_i (.clk(clk), .resetn(resetn), .run(run),
    .mnt_part(mnt_part), .mnt_addr(mnt_addr), .mnt_wdata(mnt_wdata), .mnt_write(mnt_write),
    .mnt_page_erase(mnt_page_erase), .mnt_all_erase(mnt_all_erase), .pc_reg(pc_reg),
    .acc_reg(acc_reg), .retire_reg(retire_reg), .ext_valid_reg(ext_valid_reg),
    .ext_instr_reg(ext_instr_reg), .mnt_rdata_reg(mnt_rdata_reg));

  scc_host_model host_i (.clk(clk), .mnt_part(mnt_part), .mnt_addr(mnt_addr),
    .mnt_wdata(mnt_wdata), .mnt_write(mnt_write), .mnt_page_erase(mnt_page_erase),
    .mnt_all_erase(mnt_all_erase));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // reset also clears the reference model, the core registers start at zero
  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (xr[i]) xr[i] = 16'h0000;
    prog.delete();
    notes.delete();
    pc_m = 16'h0000;
    cyc = 0;
  endtask

  // the read byte lands one edge after the address, so sample just past it
  task automatic rd_chk(input logic part, input logic [15:0] addr, input logic [7:0] exp);
    host_i.mop(2'd3, part, addr, 8'h00);
    #1;
    check({8'h00, mnt_rdata_reg}, {8'h00, exp}, "flash byte");
  endtask

  // append one instruction and predict its effect
  task automatic emit(input logic [3:0] op, input logic [3:0] s, input logic [15:0] imm);
    scc_note_t n;
    logic [15:0] v;
    v = xr[s];
    prog.push_back({op, s});
    n.ext = 1'b0;
    n.eb = 8'h00;
    cyc++;
    pc_m++;
    case (op)
      4'h0: begin
        prog.push_back(imm[15:8]);
        prog.push_back(imm[7:0]);
        xr[s] = imm;
        cyc += 2;
        pc_m += 2;
      end
      4'h1: xr[s] = 16'h0000;
      4'h2: xr[ACC] = xr[ACC] & v;
      4'h3: xr[ACC] = xr[ACC] | v;
      4'h4: xr[ACC] = xr[ACC] + v;
      4'h5: xr[s] = xr[ACC];
      4'h6: xr[s] = {v[14:0], (s == 4'h6) ? xr[4][15] : 1'b0};
      4'h7: xr[s] = {v[15], v[15:1]};
      default: begin
        n.ext = 1'b1;
        n.eb = {op, s};
      end
    endcase
    n.acc = xr[ACC];
    n.pc = pc_m;
    notes.push_back(n);
  endtask

  // run stays high for exactly the predicted number of cycles
  task automatic run_prog();
    host_i.mop(2'd2, 1'b0, 16'h0000, 8'hff);
    foreach (prog[i]) host_i.mop(2'd0, 1'b0, 16'(i), prog[i]);
    @(posedge clk);
    run <= 1'b1;
    repeat (cyc) @(posedge clk);
    run <= 1'b0;
    repeat (4) @(posedge clk);
    check(16'(notes.size()), 16'h0000, "instructions left");
    check(pc_reg, pc_m, "pc held after run");
  endtask

  // each retire or ext pulse consumes the oldest prediction
  always @(negedge clk) begin
    if (retire_reg === 1'b1 || ext_valid_reg === 1'b1) begin
      if (notes.size() == 0) begin
        check(16'h0001, 16'h0000, "unexpected retire");
      end else begin
        mon_n = notes.pop_front();
        check(acc_reg, mon_n.acc, "acc");
        check(pc_reg, mon_n.pc, "pc");
        check({15'h0, ext_valid_reg}, {15'h0, mon_n.ext}, "ext flag");
        if (mon_n.ext) check({8'h00, ext_instr_reg}, {8'h00, mon_n.eb}, "ext byte");
      end
    end
  end

  initial begin
    #100000;
    num_errors++;
    final_report();
  end

  initial begin
    do_reset();
    check(pc_reg, 16'h0000, "pc after reset");
    check(acc_reg, 16'h0000, "acc after reset");
    // partition isolation: erases on one side leave the other alone
    host_i.mop(2'd2, 1'b1, 16'h0000, 8'hff);
    // flash has no reset, so the program side is erased before a bit-clearing write
    host_i.mop(2'd2, 1'b0, 16'h0000, 8'hff);
    host_i.mop(2'd0, 1'b1, 16'h0045, 8'h3c);
    host_i.mop(2'd0, 1'b1, 16'h007f, 8'h81);
    host_i.mop(2'd0, 1'b1, 16'h0010, 8'h00);
    host_i.mop(2'd0, 1'b0, 16'h0123, 8'h5a);
    host_i.mop(2'd1, 1'b1, 16'h0000, 8'hff);
    rd_chk(1'b1, 16'h0010, 8'hff);
    rd_chk(1'b1, 16'h0045, 8'h3c);
    rd_chk(1'b1, 16'h007f, 8'h81);
    rd_chk(1'b0, 16'h0123, 8'h5a);
    rd_chk(1'b0, 16'hf123, 8'h5a);
    host_i.mop(2'd1, 1'b0, 16'h0100, 8'hff);
    rd_chk(1'b0, 16'h0123, 8'hff);
    host_i.mop(2'd2, 1'b0, 16'h0000, 8'hff);
    rd_chk(1'b1, 16'h0045, 8'h3c);
    // program: load all registers, chained shifts, random ops, ext ops, readback
    do_reset();
    for (int s = 0; s < 16; s++) begin
      rnd = $random(seed);
      emit(4'h0, 4'(s), rnd[15:0]);
    end
    emit(4'h0, 4'h4, 16'h8000);
    emit(4'h6, 4'h6, 16'h0000);
    emit(4'h0, 4'h4, 16'h7fff);
    emit(4'h6, 4'h6, 16'h0000);
    for (int k = 0; k < 56; k++) begin
      rnd = $random(seed);
      emit(4'(k % 7 + 1), rnd[3:0], 16'h0000);
    end
    for (int o = 8; o < 16; o++) begin
      rnd = $random(seed);
      emit(4'(o), rnd[3:0], 16'h0000);
    end
    for (int s = 0; s < 16; s++) begin
      emit(4'h1, ACC, 16'h0000);
      emit(4'h3, 4'(s), 16'h0000);
    end
    run_prog();
    rd_chk(1'b1, 16'h0045, 8'h3c);
    final_report();
  end
endmodule
